// ===== hdl/mbx_map.svh
`ifndef MBX_MAP_SVH
`define MBX_MAP_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define MBX_W 36
`define MBX_PTR_W 10
`define MBX_OFS_W 9

// ----------------------------------------
// Queue depth and reset values
// ----------------------------------------
`define MBX_DEPTH 10'h200
`define MBX_OFS_RST 9'h008
`define MBX_FLAG_RST 4'hC

// ----------------------------------------
// Flag vector bit positions
// ----------------------------------------
`define MBX_F_IR 3
`define MBX_F_AF 2
`define MBX_F_AE 1
`define MBX_F_OR 0

`endif

// ===== hdl/mbx_pkg.sv
`default_nettype none
`include "mbx_map.svh"

package mbx_pkg;

  typedef logic [3:0] mbx_flag_t;

  typedef enum logic [4:0] {
    MBX_PROG_Y1 = 5'h01,
    MBX_PROG_X1 = 5'h02,
    MBX_PROG_Y2 = 5'h04,
    MBX_PROG_X2 = 5'h08,
    MBX_PROG_DONE = 5'h10
  } mbx_prog_e;

  typedef struct packed {
    logic [`MBX_W-1:0] word;
    logic flag_n;
  } mbx_box_s;

  typedef struct packed {
    mbx_flag_t s1;
    mbx_flag_t s2;
  } mbx_sync_s;

  typedef struct packed {
    logic a_clk_q;
    logic b_clk_q;
    logic [`MBX_PTR_W-1:0] ab_wptr;
    logic [`MBX_PTR_W-1:0] ab_rptr;
    logic [`MBX_PTR_W-1:0] ba_wptr;
    logic [`MBX_PTR_W-1:0] ba_rptr;
    logic ab_or;
    logic ba_or;
    logic [`MBX_W-1:0] ab_out;
    logic [`MBX_W-1:0] ba_out;
    logic [`MBX_W-1:0] a_dout;
    logic [`MBX_W-1:0] b_dout;
    logic a_oe;
    logic b_oe;
    logic [`MBX_OFS_W-1:0] ab_near_empty_offset;
    logic [`MBX_OFS_W-1:0] ab_near_full_offset;
    logic [`MBX_OFS_W-1:0] ba_near_empty_offset;
    logic [`MBX_OFS_W-1:0] ba_near_full_offset;
    mbx_prog_e prog;
    logic ab_push;
    logic ab_pop;
    logic ba_push;
    logic ba_pop;
  } mbx_top_s;

endpackage : mbx_pkg

`default_nettype wire

// ===== hdl/mbx_box_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "mbx_map.svh"

interface mbx_box_if;
  logic wr;
  logic rd;
  logic [`MBX_W-1:0] wdata;
  logic [`MBX_W-1:0] word;
  logic flag_n;

  modport box (input wr, input rd, input wdata, output word, output flag_n);
  modport user (output wr, output rd, output wdata, input word, input flag_n);
endinterface : mbx_box_if

`default_nettype wire

// ===== hdl/mbx_box.sv
`timescale 1ns/10ps
`default_nettype none
`include "mbx_map.svh"

module mbx_box (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Mailbox access
  mbx_box_if.box bx
);

  mbx_pkg::mbx_box_s s;
  mbx_pkg::mbx_box_s next_s;

  always_comb begin
    next_s = s;
    // Read empties the box; the word itself stays
    if (bx.rd) begin
      next_s.flag_n = 1'b1;
    end
    // Write only while empty; a write wins over a same-cycle read
    if (bx.wr && s.flag_n) begin
      next_s.word = bx.wdata;
      next_s.flag_n = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s.word <= '0;
      s.flag_n <= 1'b1;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign bx.word = s.word;
  assign bx.flag_n = s.flag_n;

endmodule : mbx_box

`default_nettype wire

// ===== hdl/mbx_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "mbx_map.svh"

module mbx_sync #(
  parameter mbx_pkg::mbx_flag_t RST = `MBX_FLAG_RST
) (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Port clock edge and flags
  input wire logic port_edge,
  input wire mbx_pkg::mbx_flag_t d,
  output mbx_pkg::mbx_flag_t q
);

  mbx_pkg::mbx_sync_s s;
  mbx_pkg::mbx_sync_s next_s;

  // Two stages, advanced only on the owning port clock edge
  always_comb begin
    next_s = s;
    if (port_edge) begin
      next_s.s1 = d;
      next_s.s2 = s.s1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s.s1 <= RST;
      s.s2 <= RST;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign q = s.s2;

endmodule : mbx_sync

`default_nettype wire

// ===== hdl/mbx_dual_box.sv
`timescale 1ns/10ps
`default_nettype none
`include "mbx_map.svh"
//
// Contract
// - Each direction has one 36-bit bypass word
// - Box select steers transfer to box or queue
// - Port A box write stores A data
// - Port B box write stores B data
// - Box write drives new-word flag low
// - Writes ignored while flag is low
// - Output data from box or queue register
// - Port B box read raises A-to-B flag
// - Port A box read raises B-to-A flag
// - Reading a box keeps its word
// - Reset loads offsets with preset eight
// - Offset writes need not be consecutive
// - Output ready and load on third edge
// - Input ready returns after read, synchronised
// - Near flags follow after synchronising edges
// - Output register word counts as read
// - Fill flags pass two stages on port clock; new-word flags are not staged

module mbx_dual_box (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Port A controls
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_direction,
  input wire logic port_a_transfer_enable,
  input wire logic port_a_box_select,
  // Port A data bus
  input wire logic [`MBX_W-1:0] port_a_data_in,
  output logic [`MBX_W-1:0] port_a_data_out,
  output logic port_a_data_oe,
  // Port A flags
  output logic port_a_input_ready,
  output logic port_a_output_ready,
  output logic port_a_near_empty_n,
  output logic port_a_near_full_n,
  output logic a_to_b_new_word_flag_n,
  // Port B controls
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic port_b_direction,
  input wire logic port_b_transfer_enable,
  input wire logic port_b_box_select,
  // Port B data bus
  input wire logic [`MBX_W-1:0] port_b_data_in,
  output logic [`MBX_W-1:0] port_b_data_out,
  output logic port_b_data_oe,
  // Port B flags
  output logic port_b_input_ready,
  output logic port_b_output_ready,
  output logic port_b_near_empty_n,
  output logic port_b_near_full_n,
  output logic b_to_a_new_word_flag_n,
  // Offset programming
  input wire logic offset_program_start,
  // Queue array side
  output logic ab_push,
  output logic ab_pop,
  output logic ba_push,
  output logic ba_pop,
  input wire logic [`MBX_W-1:0] ab_head_word,
  input wire logic [`MBX_W-1:0] ba_head_word
);

  mbx_pkg::mbx_top_s s;
  mbx_pkg::mbx_top_s next_s;

  logic a_edge;
  logic b_edge;
  logic a_sel;
  logic b_sel;
  logic a_wr;
  logic a_rd;
  logic b_wr;
  logic b_rd;
  logic prog_wr;
  logic ab_push_c;
  logic ba_push_c;
  logic ab_pop_c;
  logic ba_pop_c;
  logic ab_rd;
  logic ba_rd;
  logic [`MBX_PTR_W-1:0] ab_lvl;
  logic [`MBX_PTR_W-1:0] ba_lvl;
  logic [`MBX_PTR_W-1:0] ab_lvl_n;
  logic [`MBX_PTR_W-1:0] ba_lvl_n;
  mbx_pkg::mbx_flag_t a_raw;
  mbx_pkg::mbx_flag_t b_raw;
  mbx_pkg::mbx_flag_t a_q;
  mbx_pkg::mbx_flag_t b_q;

  mbx_box_if ab_if ();
  mbx_box_if ba_if ();

  // ----------------------------------------
  // Port decode
  // ----------------------------------------
  always_comb begin
    a_edge = port_a_clock & ~s.a_clk_q;
    b_edge = port_b_clock & ~s.b_clk_q;
    a_sel = a_edge & ~port_a_select_n & port_a_transfer_enable;
    b_sel = b_edge & ~port_b_select_n & port_b_transfer_enable;
    a_wr = a_sel & port_a_direction;
    a_rd = a_sel & ~port_a_direction;
    b_wr = b_sel & ~port_b_direction;
    b_rd = b_sel & port_b_direction;
  end

  // ----------------------------------------
  // Bypass boxes
  // ----------------------------------------
  assign ab_if.wr = a_wr & port_a_box_select;
  assign ab_if.rd = b_rd & port_b_box_select;
  assign ab_if.wdata = port_a_data_in;
  assign ba_if.wr = b_wr & port_b_box_select;
  assign ba_if.rd = a_rd & port_a_box_select;
  assign ba_if.wdata = port_b_data_in;

  // One 36-bit word each way
  mbx_box u_ab_box (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .bx(ab_if)
  );

  mbx_box u_ba_box (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .bx(ba_if)
  );

  // ----------------------------------------
  // Queue pointers, output registers, offsets
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.a_clk_q = port_a_clock;
    next_s.b_clk_q = port_b_clock;
    // Pointers count words moved to the output register
    ab_lvl = s.ab_wptr - s.ab_rptr;
    ba_lvl = s.ba_wptr - s.ba_rptr;

    // Offset words come in as plain port A queue writes
    prog_wr = a_wr & ~port_a_box_select & (s.prog != mbx_pkg::MBX_PROG_DONE);
    if (offset_program_start) begin
      next_s.prog = mbx_pkg::MBX_PROG_Y1;
    end else if (prog_wr) begin
      unique case (s.prog)
        mbx_pkg::MBX_PROG_Y1: begin
          next_s.ab_near_full_offset = port_a_data_in[`MBX_OFS_W-1:0];
          next_s.prog = mbx_pkg::MBX_PROG_X1;
        end
        mbx_pkg::MBX_PROG_X1: begin
          next_s.ab_near_empty_offset = port_a_data_in[`MBX_OFS_W-1:0];
          next_s.prog = mbx_pkg::MBX_PROG_Y2;
        end
        mbx_pkg::MBX_PROG_Y2: begin
          next_s.ba_near_full_offset = port_a_data_in[`MBX_OFS_W-1:0];
          next_s.prog = mbx_pkg::MBX_PROG_X2;
        end
        mbx_pkg::MBX_PROG_X2: begin
          next_s.ba_near_empty_offset = port_a_data_in[`MBX_OFS_W-1:0];
          next_s.prog = mbx_pkg::MBX_PROG_DONE;
        end
        default: begin
          next_s.prog = mbx_pkg::MBX_PROG_DONE;
        end
      endcase
    end

    // Writes refused while input ready is low
    ab_push_c = a_wr & ~port_a_box_select & (s.prog == mbx_pkg::MBX_PROG_DONE)
              & a_q[`MBX_F_IR] & (ab_lvl != `MBX_DEPTH);
    ba_push_c = b_wr & ~port_b_box_select & b_q[`MBX_F_IR]
              & (ba_lvl != `MBX_DEPTH);

    // Reads refused while output ready is low
    ab_rd = b_rd & ~port_b_box_select & s.ab_or;
    ba_rd = a_rd & ~port_a_box_select & s.ba_or;
    // Load once the word has passed two reader stages
    ab_pop_c = b_edge & b_q[`MBX_F_OR] & (ab_lvl != '0) & (~s.ab_or | ab_rd);
    ba_pop_c = a_edge & a_q[`MBX_F_OR] & (ba_lvl != '0) & (~s.ba_or | ba_rd);

    if (ab_push_c) begin
      next_s.ab_wptr = s.ab_wptr + 10'h001;
    end
    if (ba_push_c) begin
      next_s.ba_wptr = s.ba_wptr + 10'h001;
    end
    if (ab_pop_c) begin
      next_s.ab_rptr = s.ab_rptr + 10'h001;
      next_s.ab_out = ab_head_word;
      next_s.ab_or = 1'b1;
    end else if (ab_rd) begin
      next_s.ab_or = 1'b0;
    end
    if (ba_pop_c) begin
      next_s.ba_rptr = s.ba_rptr + 10'h001;
      next_s.ba_out = ba_head_word;
      next_s.ba_or = 1'b1;
    end else if (ba_rd) begin
      next_s.ba_or = 1'b0;
    end
    next_s.ab_push = ab_push_c;
    next_s.ab_pop = ab_pop_c;
    next_s.ba_push = ba_push_c;
    next_s.ba_pop = ba_pop_c;

    // Raw fill flags, before the port stages
    ab_lvl_n = next_s.ab_wptr - next_s.ab_rptr;
    ba_lvl_n = next_s.ba_wptr - next_s.ba_rptr;
    a_raw[`MBX_F_IR] = ab_lvl_n != `MBX_DEPTH;
    a_raw[`MBX_F_AF] = ab_lvl_n < (`MBX_DEPTH - {1'b0, s.ab_near_full_offset});
    a_raw[`MBX_F_AE] = ba_lvl_n > {1'b0, s.ba_near_empty_offset};
    a_raw[`MBX_F_OR] = ba_lvl_n != '0;
    b_raw[`MBX_F_IR] = ba_lvl_n != `MBX_DEPTH;
    b_raw[`MBX_F_AF] = ba_lvl_n < (`MBX_DEPTH - {1'b0, s.ba_near_full_offset});
    b_raw[`MBX_F_AE] = ab_lvl_n > {1'b0, s.ab_near_empty_offset};
    b_raw[`MBX_F_OR] = ab_lvl_n != '0;

    // Port output drivers
    next_s.a_oe = ~port_a_select_n & ~port_a_direction;
    next_s.a_dout = port_a_box_select ? ba_if.word : s.ba_out;
    next_s.b_oe = ~port_b_select_n & port_b_direction;
    next_s.b_dout = port_b_box_select ? ab_if.word : s.ab_out;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.ab_near_empty_offset <= `MBX_OFS_RST;
      s.ab_near_full_offset <= `MBX_OFS_RST;
      s.ba_near_empty_offset <= `MBX_OFS_RST;
      s.ba_near_full_offset <= `MBX_OFS_RST;
      s.prog <= mbx_pkg::MBX_PROG_DONE;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Port flag stages
  // ----------------------------------------
  mbx_sync u_a_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .port_edge(a_edge),
    .d(a_raw),
    .q(a_q)
  );

  mbx_sync u_b_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .port_edge(b_edge),
    .d(b_raw),
    .q(b_q)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign port_a_data_out = s.a_dout;
  assign port_a_data_oe = s.a_oe;
  assign port_a_input_ready = a_q[`MBX_F_IR];
  assign port_a_near_full_n = a_q[`MBX_F_AF];
  assign port_a_near_empty_n = a_q[`MBX_F_AE];
  assign port_a_output_ready = s.ba_or;
  assign a_to_b_new_word_flag_n = ab_if.flag_n;
  assign port_b_data_out = s.b_dout;
  assign port_b_data_oe = s.b_oe;
  assign port_b_input_ready = b_q[`MBX_F_IR];
  assign port_b_near_full_n = b_q[`MBX_F_AF];
  assign port_b_near_empty_n = b_q[`MBX_F_AE];
  assign port_b_output_ready = s.ab_or;
  assign b_to_a_new_word_flag_n = ba_if.flag_n;
  assign ab_push = s.ab_push;
  assign ab_pop = s.ab_pop;
  assign ba_push = s.ba_push;
  assign ba_pop = s.ba_pop;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_ab_box_store: assert property (
    clk_en && ab_if.wr && ab_if.flag_n |=> !a_to_b_new_word_flag_n && ab_if.word == $past(port_a_data_in))
    else $error("a-to-b box write not stored");
  a_ba_box_store: assert property (
    clk_en && ba_if.wr && ba_if.flag_n |=> !b_to_a_new_word_flag_n && ba_if.word == $past(port_b_data_in))
    else $error("b-to-a box write not stored");
  a_box_full_hold: assert property (
    !ab_if.flag_n && !ab_if.rd |=> $stable(ab_if.word) && !ab_if.flag_n)
    else $error("full box changed");
  a_ab_read_clear: assert property (
    clk_en && ab_if.rd |=> a_to_b_new_word_flag_n || $past(ab_if.wr && ab_if.flag_n))
    else $error("a-to-b flag not raised by read");
  a_ba_read_clear: assert property (
    clk_en && ba_if.rd && !ba_if.wr |=> b_to_a_new_word_flag_n && $stable(ba_if.word))
    else $error("b-to-a read wrong");
  a_port_mux: assert property (
    clk_en && port_a_box_select |=> port_a_data_out == $past(ba_if.word))
    else $error("port a box data not driven");
  a_offset_reset: assert property (
    $past(sys_rst) |-> s.ab_near_empty_offset == `MBX_OFS_RST && s.ba_near_full_offset == `MBX_OFS_RST)
    else $error("offsets not preset");
  a_offset_load: assert property (
    clk_en && prog_wr && s.prog == mbx_pkg::MBX_PROG_Y1 && !offset_program_start
    |=> s.ab_near_full_offset == $past(port_a_data_in[`MBX_OFS_W-1:0]))
    else $error("offset word lost");
  a_or_by_load: assert property (
    $rose(port_b_output_ready) |-> ab_pop && s.ab_rptr == $past(s.ab_rptr) + 10'h001)
    else $error("output ready without load");
  a_level_bound: assert property (
    ab_lvl <= `MBX_DEPTH && ba_lvl <= `MBX_DEPTH)
    else $error("queue overfilled");
  a_flag_on_edge: assert property (
    $changed(port_a_input_ready) || $changed(port_a_near_empty_n) |-> $past(a_edge && clk_en))
    else $error("port a flag moved off its edge");
  a_dir_decode: assert property (
    b_sel && port_b_direction || !port_b_box_select |-> !ba_if.wr)
    else $error("port b direction decode wrong");

  c_ab_mail: cover property (ab_if.wr && ab_if.flag_n ##[1:20] ab_if.rd);
  c_ba_mail: cover property (ba_if.wr && ba_if.flag_n ##[1:20] ba_if.rd);
  c_fifo_load: cover property (ab_push ##[1:20] $rose(port_b_output_ready));
  c_prog_done: cover property (prog_wr && s.prog == mbx_pkg::MBX_PROG_X2);

endmodule : mbx_dual_box

`default_nettype wire

// ===== bench/mbx_array_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "mbx_map.svh"

// ----------------------------------------
// Queue array behind the push/pop side
// ----------------------------------------
module mbx_array_model (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Array side
  input wire logic push,
  input wire logic pop,
  input wire logic [`MBX_W-1:0] din,
  output logic [`MBX_W-1:0] head
);
  logic [`MBX_W-1:0] mem [0:511];
  logic [`MBX_W-1:0] din_q;
  logic [`MBX_W-1:0] junk;
  logic [9:0] wp;
  logic [9:0] rp;

  // Empty array shows a word that changes every cycle
  assign head = (wp != rp) ? mem[rp[8:0]] : junk;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wp <= 10'h000;
      rp <= 10'h000;
      din_q <= 36'h000000000;
      junk <= 36'hA5A5A5A5A;
    end else begin
      din_q <= din;
      junk <= ~junk;
      if (pop && wp != rp) begin
        rp <= rp + 10'h001;
      end
      // Push carries the data of the cycle before
      if (push) begin
        mem[wp[8:0]] <= din_q;
        wp <= wp + 10'h001;
      end
    end
  end
endmodule : mbx_array_model

`default_nettype wire

// ===== bench/tb_dual_port_mailbox_bypass.sv
`timescale 1ns/10ps
`default_nettype none
`include "mbx_map.svh"

module tb_dual_port_mailbox_bypass;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic offset_program_start = 1'b0;
  logic [4:0] a_ctl = 5'h08;
  logic [4:0] b_ctl = 5'h08;
  logic [`MBX_W-1:0] port_a_data_in = 36'h000000000;
  logic [`MBX_W-1:0] port_b_data_in = 36'h000000000;
  wire logic port_a_clock, port_a_select_n, port_a_direction, port_a_transfer_enable, port_a_box_select;
  wire logic port_b_clock, port_b_select_n, port_b_direction, port_b_transfer_enable, port_b_box_select;
  logic [`MBX_W-1:0] port_a_data_out, port_b_data_out, ab_head_word, ba_head_word;
  logic port_a_data_oe, port_a_input_ready, port_a_output_ready, port_a_near_empty_n, port_a_near_full_n;
  logic port_b_data_oe, port_b_input_ready, port_b_output_ready, port_b_near_empty_n, port_b_near_full_n;
  logic a_to_b_new_word_flag_n, b_to_a_new_word_flag_n, ab_push, ab_pop, ba_push, ba_pop;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] seed = 32'h00006DEC;
  logic [`MBX_W-1:0] exp_a [$];
  logic [`MBX_W-1:0] exp_b [$];
  logic [`MBX_W-1:0] words [$];
  localparam logic [8:0] OFS [4] = '{9'h004, 9'h003, 9'h005, 9'h001};

  assign {port_a_clock, port_a_select_n, port_a_direction, port_a_transfer_enable, port_a_box_select} = a_ctl;
  assign {port_b_clock, port_b_select_n, port_b_direction, port_b_transfer_enable, port_b_box_select} = b_ctl;

  mbx_dual_box i_dut (.clk_sys, .sys_rst, .clk_en, .port_a_clock, .port_a_select_n, .port_a_direction,
    .port_a_transfer_enable, .port_a_box_select, .port_a_data_in, .port_a_data_out, .port_a_data_oe,
    .port_a_input_ready, .port_a_output_ready, .port_a_near_empty_n, .port_a_near_full_n,
    .a_to_b_new_word_flag_n, .port_b_clock, .port_b_select_n, .port_b_direction, .port_b_transfer_enable,
    .port_b_box_select, .port_b_data_in, .port_b_data_out, .port_b_data_oe, .port_b_input_ready,
    .port_b_output_ready, .port_b_near_empty_n, .port_b_near_full_n, .b_to_a_new_word_flag_n,
    .offset_program_start, .ab_push, .ab_pop, .ba_push, .ba_pop, .ab_head_word, .ba_head_word);
  mbx_array_model i_ab (.clk_sys, .sys_rst, .push(ab_push), .pop(ab_pop), .din(port_a_data_in),
    .head(ab_head_word));
  mbx_array_model i_ba (.clk_sys, .sys_rst, .push(ba_push), .pop(ba_pop), .din(port_b_data_in),
    .head(ba_head_word));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [`MBX_W-1:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return {seed[3:0], seed};
  endfunction : rnd

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [`MBX_W-1:0] got, input logic [`MBX_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: data %h, expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic note(input bit p, input logic [`MBX_W-1:0] d);
    if (p) exp_b.push_back(d);
    else exp_a.push_back(d);
  endtask : note

  // One port clock pulse with its controls held across the sampling edge
  task automatic xfer(input bit p, input logic sel_n, input logic wr, input logic en, input logic box,
                      input logic [`MBX_W-1:0] d);
    @(posedge clk_sys);
    #1;
    if (!p) begin
      a_ctl = {1'b1, sel_n, wr, en, box};
      port_a_data_in = d;
    end else begin
      b_ctl = {1'b1, sel_n, !wr, en, box};
      port_b_data_in = d;
    end
    @(posedge clk_sys);
    #1;
    if (!p) begin
      a_ctl = 5'h08;
      port_a_data_in = ~d;
    end else begin
      b_ctl = 5'h08;
      port_b_data_in = ~d;
    end
    @(posedge clk_sys);
    #1;
  endtask : xfer

  task automatic idle(input bit p, input int n);
    repeat (n) xfer(p, 1'b1, 1'b0, 1'b0, 1'b0, 36'h000000000);
  endtask : idle

  task automatic summarize();
    if (exp_a.size() + exp_b.size() != 0) mismatches++;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  // Sampled mid-cycle, away from the launching edge
  always @(negedge clk_sys) begin
    if (port_a_data_oe === 1'b1 && exp_a.size() > 0) chk_word(port_a_data_out, exp_a.pop_front());
    if (port_b_data_oe === 1'b1 && exp_b.size() > 0) chk_word(port_b_data_out, exp_b.pop_front());
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin : main
    logic [`MBX_W-1:0] w;
    logic [`MBX_W-1:0] d1;
    logic [`MBX_W-1:0] d2;
    bit pb;
    repeat (8) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    chk_bit(a_to_b_new_word_flag_n, 1'b1);
    chk_bit(port_b_output_ready, 1'b0);
    // Mailbox each way, second write while full is dropped
    for (int p = 0; p < 2; p++) begin
      pb = p[0];
      d1 = rnd();
      d2 = rnd();
      xfer(pb, 1'b0, 1'b1, 1'b1, 1'b1, d1);
      chk_bit(pb ? b_to_a_new_word_flag_n : a_to_b_new_word_flag_n, 1'b0);
      xfer(pb, 1'b0, 1'b1, 1'b1, 1'b1, d2);
      note(!pb, d1);
      xfer(!pb, 1'b0, 1'b0, 1'b1, 1'b1, 36'h000000000);
      chk_bit(pb ? b_to_a_new_word_flag_n : a_to_b_new_word_flag_n, 1'b1);
      note(!pb, d1);
      xfer(!pb, 1'b0, 1'b0, 1'b0, 1'b1, 36'h000000000);
      idle(!pb, 3);
      chk_bit(pb ? port_a_output_ready : port_b_output_ready, 1'b0);
      xfer(pb, 1'b0, 1'b1, 1'b1, 1'b1, d2);
      note(!pb, d2);
      xfer(!pb, 1'b0, 1'b0, 1'b1, 1'b1, 36'h000000000);
    end
    // Box write ignored while clock enable is low
    clk_en = 1'b0;
    xfer(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, rnd());
    clk_en = 1'b1;
    chk_bit(a_to_b_new_word_flag_n, 1'b1);
    // B to A queue with preset offsets
    for (int i = 0; i < 10; i++) begin
      w = rnd();
      words.push_back(w);
      xfer(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, w);
      idle(1'b0, 2);
      if (i == 0) chk_bit(port_a_output_ready, 1'b0);
      if (i == 0) idle(1'b0, 1);
      if (i == 0) chk_bit(port_a_output_ready, 1'b1);
      if (i == 8) chk_bit(port_a_near_empty_n, 1'b0);
      if (i == 9) chk_bit(port_a_near_empty_n, 1'b1);
      if (i == 9) chk_bit(port_b_input_ready, 1'b1);
      if (i == 9) chk_bit(port_b_near_full_n, 1'b1);
    end
    note(1'b0, words[0]);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 36'h000000000);
    words.delete();
    // Offsets loaded with gaps between writes
    @(posedge clk_sys);
    #1;
    offset_program_start = 1'b1;
    @(posedge clk_sys);
    #1;
    offset_program_start = 1'b0;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, {27'h0000000, OFS[i]});
      idle(1'b0, 1);
    end
    // Fill A to B until refused
    for (int i = 0; i < 513; i++) begin
      w = rnd();
      if (i < 512) words.push_back(w);
      xfer(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, w);
      if (i == 506 || i == 507 || i == 511) idle(1'b0, 2);
      if (i == 506) chk_bit(port_a_near_full_n, 1'b1);
      if (i == 507) chk_bit(port_a_near_full_n, 1'b0);
      if (i == 511) chk_bit(port_a_input_ready, 1'b0);
    end
    idle(1'b1, 2);
    chk_bit(port_b_output_ready, 1'b0);
    idle(1'b1, 1);
    chk_bit(port_b_output_ready, 1'b1);
    idle(1'b0, 2);
    chk_bit(port_a_input_ready, 1'b1);
    w = rnd();
    words.push_back(w);
    xfer(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, w);
    // Drain in order
    for (int i = 0; i < 513; i++) begin
      note(1'b1, words[i]);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 36'h000000000);
      if (i == 508) chk_bit(port_b_near_empty_n, 1'b1);
      if (i == 509) chk_bit(port_b_near_empty_n, 1'b0);
      xfer(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 36'h000000000);
      idle(1'b1, 2);
    end
    chk_bit(port_b_output_ready, 1'b0);
    summarize();
  end
endmodule : tb_dual_port_mailbox_bypass

`default_nettype wire
